// [include/acscr_consts.svh]
// constants for the converter configuration register bank
// assumes a 20 MHz core clock and a serial port sampled by that clock
`ifndef ACSCR_CONSTS_SVH
`define ACSCR_CONSTS_SVH
`define ACSCR_ADDR_PAIR_A 4'h0
`define ACSCR_ADDR_PAIR_B 4'h1
`define ACSCR_ADDR_PAIR_C 4'h2
`define ACSCR_ADDR_PAIR_D 4'h3
`define ACSCR_ADDR_CHSEL 4'h4
`define ACSCR_ADDR_SYSCFG 4'h5
`define ACSCR_ADDR_IRQ 4'h6
`define ACSCR_OP_WRITE 2'h2
`define ACSCR_OP_READ 2'h1
`define ACSCR_FRAME_BITS 5'h10
`define ACSCR_DATA_FIRST_BIT 5'h08
`define ACSCR_RESET_BYTE 8'h00
`define ACSCR_PAIR_MASK 8'h3F
`define ACSCR_CHSEL_MASK 8'h07
`define ACSCR_IRQ_MASK 8'h8F
`define ACSCR_PULSE_NS 250
`define ACSCR_CLK_MHZ 20
`endif

// [include/acscr_pkg.sv]
// types for the converter configuration register bank
// shared by the top module and its serial helper
package acscr_pkg;
    typedef struct packed {
        logic [1:0] odd_gain;
        logic polarity_odd;
        logic differential;
        logic [1:0] even_gain;
    } acscr_pair_t;
    typedef struct packed {
        logic [2:0] average_sel;
        logic irq_edge;
        logic pin_active_high;
        logic pin_is_busy;
        logic fifo_enable;
        logic start_from_read;
    } acscr_sys_t;
    typedef struct packed {
        logic fifo_not_empty;
        logic fifo_full;
        logic scan_ready;
        logic data_ready;
    } acscr_events_t;
    typedef struct packed {
        logic is_write;
        logic is_read;
        logic [3:0] addr;
        logic [7:0] data;
    } acscr_access_t;
endpackage

// [src/acscr_sync.sv]
// two-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk
`timescale 1ns/10ps
module acscr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // acscr_sync

// [src/acscr_serial.sv]
// serial frame receiver/transmitter, oversampled by clk
// assumes synchronised select, clock and data inputs; mode 0 framing
`timescale 1ns/10ps
`include "acscr_consts.svh"
module acscr_serial (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic [7:0] rd_data,
    output acscr_pkg::acscr_access_t acc,
    output logic acc_valid,
    output logic [3:0] rd_addr,
    output logic sdout,
    output logic sdout_oe
);
    logic sclk_d_reg;
    logic [4:0] cnt_reg;
    logic [15:0] shift_reg;
    logic [7:0] tx_reg;
    wire sclk_rise = sclk & ~sclk_d_reg & ~cs_n;
    wire sclk_fall = ~sclk & sclk_d_reg & ~cs_n;
    wire [15:0] frame = {shift_reg[14:0], sdin};
    wire frame_done = sclk_rise &&
        (cnt_reg == `ACSCR_FRAME_BITS - 5'h01);
    wire load_tx = sclk_fall && (cnt_reg == `ACSCR_DATA_FIRST_BIT);
    assign rd_addr = shift_reg[5:2];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b0;
            cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            tx_reg <= 8'h00;
            acc <= '0;
            acc_valid <= 1'b0;
            sdout <= 1'b0;
            sdout_oe <= 1'b0;
        end else begin
            sclk_d_reg <= sclk;
            acc_valid <= frame_done;
            sdout_oe <= ~cs_n;
            if (cs_n) begin
                cnt_reg <= 5'h00;
                sdout <= 1'b0;
            end else if (sclk_rise) begin
                shift_reg <= frame;
                cnt_reg <= frame_done ? 5'h00 : cnt_reg + 5'h01;
            end
            if (frame_done) begin
                acc.is_write <= frame[15:14] == `ACSCR_OP_WRITE;
                acc.is_read <= frame[15:14] == `ACSCR_OP_READ;
                acc.addr <= frame[13:10];
                acc.data <= frame[7:0];
            end
            // read data leaves msb first from bit 8 onward
            if (load_tx) begin
                sdout <= rd_data[7];
                tx_reg <= {rd_data[6:0], 1'b0};
            end else if (sclk_fall && cnt_reg > `ACSCR_DATA_FIRST_BIT) begin
                sdout <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end else if (sclk_fall) begin
                sdout <= 1'b0;
            end
        end
    end
endmodule // acscr_serial

// [src/acscr_top.sv]
// configuration register bank of an eight channel sampling converter
// assumes serial pins from a host, event levels from converter logic
`timescale 1ns/10ps
`include "acscr_consts.svh"
module acscr_top #(
    parameter int PULSE_NS = `ACSCR_PULSE_NS,
    parameter int CLK_MHZ = `ACSCR_CLK_MHZ
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SOFT_RESET,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic SDIN,
    output logic SDOUT,
    output logic SDOUT_OE,
    input wire logic AUTO_SCAN_MODE,
    input wire logic CONV_BUSY,
    input wire logic RESULT_READ,
    input wire acscr_pkg::acscr_events_t EVENTS,
    output acscr_pkg::acscr_pair_t [3:0] PAIR_CFG,
    output logic [2:0] CHANNEL_SEL,
    output acscr_pkg::acscr_sys_t SYS_CFG,
    output logic POWER_DOWN,
    output logic [3:0] IRQ_ENABLE,
    output logic SERIAL_START,
    output logic BUSY_INT_PIN
);
    // pulse length rounded down, at least one cycle
    localparam int PULSE_RAW = (PULSE_NS * CLK_MHZ) / 1000;
    localparam int PULSE_CYC = PULSE_RAW < 1 ? 1 : PULSE_RAW;
    localparam logic [7:0] PULSE_LEN = 8'(PULSE_CYC);

    logic rst_meta_reg;
    logic rst_n_reg;
    logic [4:0] pin_sync;
    logic cs_n_s, sclk_s, sdin_s, soft_s, busy_s;
    acscr_pkg::acscr_access_t acc;
    logic acc_valid;
    logic [3:0] rd_addr;
    logic sdout_w, sdout_oe_w;
    logic [7:0] pair_reg [4];
    logic [7:0] chsel_reg;
    logic [7:0] sys_reg;
    logic [7:0] irq_reg;
    logic soft_d_reg;
    logic irq_level_d_reg;
    logic [7:0] pulse_cnt_reg;
    acscr_pkg::acscr_sys_t sys_f;
    logic [3:0] status_w;
    logic [7:0] rd_data;
    logic irq_level;
    logic irq_active;
    logic pin_active;

    // reset release through two flops
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    acscr_sync #(.WIDTH(5)) u_sync (
        .clk(CLK),
        .rst_n(rst_n_reg),
        .d({~CS_N, SCLK, SDIN, SOFT_RESET, CONV_BUSY}),
        .q(pin_sync)
    );
    // select travels inverted so the synchroniser's reset reads deselected
    assign cs_n_s = ~pin_sync[4];
    assign sclk_s = pin_sync[3];
    assign sdin_s = pin_sync[2];
    assign soft_s = pin_sync[1];
    assign busy_s = pin_sync[0];

    acscr_serial u_serial (
        .clk(CLK),
        .rst_n(rst_n_reg),
        .cs_n(cs_n_s),
        .sclk(sclk_s),
        .sdin(sdin_s),
        .rd_data(rd_data),
        .acc(acc),
        .acc_valid(acc_valid),
        .rd_addr(rd_addr),
        .sdout(sdout_w),
        .sdout_oe(sdout_oe_w)
    );

    // soft reset is a rising edge of the synchronised SOFT_RESET pin
    wire soft_hit = soft_s & ~soft_d_reg;
    wire wr = acc_valid & acc.is_write;
    wire wr_pair = wr && acc.addr <= `ACSCR_ADDR_PAIR_D;
    wire wr_chsel = wr && acc.addr == `ACSCR_ADDR_CHSEL;
    wire wr_sys = wr && acc.addr == `ACSCR_ADDR_SYSCFG;
    wire wr_irq = wr && acc.addr == `ACSCR_ADDR_IRQ;
    wire [1:0] pair_idx = acc.addr[1:0];

    // raised flags: enabled and present; scan flag only in auto scan
    assign status_w[3] = irq_reg[3] & EVENTS.fifo_not_empty;
    assign status_w[2] = irq_reg[2] & EVENTS.fifo_full;
    assign status_w[1] = irq_reg[1] & EVENTS.scan_ready
        & AUTO_SCAN_MODE;
    assign status_w[0] = irq_reg[0] & EVENTS.data_ready;

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_data = `ACSCR_RESET_BYTE;
        case (rd_addr)
            `ACSCR_ADDR_PAIR_A,
            `ACSCR_ADDR_PAIR_B,
            `ACSCR_ADDR_PAIR_C,
            `ACSCR_ADDR_PAIR_D: rd_data = pair_reg[rd_addr[1:0]];
            `ACSCR_ADDR_CHSEL: rd_data = chsel_reg;
            `ACSCR_ADDR_SYSCFG: rd_data = sys_reg;
            `ACSCR_ADDR_IRQ: rd_data = {irq_reg[7], 3'h0,
                status_w};
            default: rd_data = `ACSCR_RESET_BYTE;
        endcase
    end

    // registers; software reset restores defaults as hardware does
    // idle-only writes are the host's duty; accepted regardless
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            for (int i = 0; i < 4; i++) begin
                pair_reg[i] <= `ACSCR_RESET_BYTE;
            end
        end else if (soft_hit) begin
            for (int i = 0; i < 4; i++) begin
                pair_reg[i] <= `ACSCR_RESET_BYTE;
            end
        end else if (wr_pair) begin
            pair_reg[pair_idx] <= acc.data & `ACSCR_PAIR_MASK;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            chsel_reg <= `ACSCR_RESET_BYTE;
        end else if (soft_hit) begin
            chsel_reg <= `ACSCR_RESET_BYTE;
        end else if (wr_chsel) begin
            chsel_reg <= acc.data & `ACSCR_CHSEL_MASK;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sys_reg <= `ACSCR_RESET_BYTE;
        end else if (soft_hit) begin
            sys_reg <= `ACSCR_RESET_BYTE;
        end else if (wr_sys) begin
            sys_reg <= acc.data;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            irq_reg <= `ACSCR_RESET_BYTE;
        end else if (soft_hit) begin
            irq_reg <= `ACSCR_RESET_BYTE;
        end else if (wr_irq) begin
            irq_reg <= acc.data & `ACSCR_IRQ_MASK;
        end
    end

    // interrupt shaping: level, or a fixed pulse on each new rise
    assign sys_f = sys_reg;
    assign irq_level = |status_w;
    wire irq_rise = irq_level & ~irq_level_d_reg;
    assign irq_active = sys_f.irq_edge ? (pulse_cnt_reg != 8'h00)
        : irq_level;
    // pin content and polarity chosen by the system register
    assign pin_active = sys_f.pin_is_busy ? busy_s : irq_active;
    wire pin_level = sys_f.pin_active_high ? pin_active
        : ~pin_active;
    wire serial_start_next = RESULT_READ & sys_f.start_from_read;

    // edge history for the soft reset and the pulse start
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            soft_d_reg <= 1'b0;
            irq_level_d_reg <= 1'b0;
        end else begin
            soft_d_reg <= soft_s;
            irq_level_d_reg <= irq_level;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pulse_cnt_reg <= 8'h00;
        end else if (soft_hit) begin
            pulse_cnt_reg <= 8'h00;
        end else if (irq_rise && sys_f.irq_edge) begin
            pulse_cnt_reg <= PULSE_LEN;
        end else if (pulse_cnt_reg != 8'h00) begin
            pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
        end
    end

    // every output is a flop copy of what it reports
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            PAIR_CFG <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                PAIR_CFG[i] <= pair_reg[i][5:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            CHANNEL_SEL <= 3'h0;
        end else begin
            CHANNEL_SEL <= chsel_reg[2:0];
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            SYS_CFG <= '0;
        end else begin
            SYS_CFG <= sys_f;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            POWER_DOWN <= 1'b0;
            IRQ_ENABLE <= 4'h0;
        end else begin
            POWER_DOWN <= irq_reg[7];
            IRQ_ENABLE <= irq_reg[3:0];
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            SERIAL_START <= 1'b0;
        end else begin
            SERIAL_START <= serial_start_next;
        end
    end

    // idle level of the default active-low pin is high
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            BUSY_INT_PIN <= 1'b1;
        end else begin
            BUSY_INT_PIN <= pin_level;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            SDOUT <= 1'b0;
            SDOUT_OE <= 1'b0;
        end else begin
            SDOUT <= sdout_w;
            SDOUT_OE <= sdout_oe_w;
        end
    end
endmodule // acscr_top

// [sim/acscr_assertions.sv]
// port checker for the converter configuration register bank
// assumes binding onto acscr_top; a single clock domain
`timescale 1ns/10ps
module acscr_assertions #(
    parameter int PULSE_NS = 250,
    parameter int CLK_MHZ = 20
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SOFT_RESET,
    input wire logic CS_N,
    input wire logic SDOUT_OE,
    input wire logic AUTO_SCAN_MODE,
    input wire logic CONV_BUSY,
    input wire logic RESULT_READ,
    input wire acscr_pkg::acscr_events_t EVENTS,
    input wire logic [2:0] CHANNEL_SEL,
    input wire acscr_pkg::acscr_sys_t SYS_CFG,
    input wire logic POWER_DOWN,
    input wire logic [3:0] IRQ_ENABLE,
    input wire logic SERIAL_START,
    input wire logic BUSY_INT_PIN
);
    localparam int PW = PULSE_NS * CLK_MHZ / 1000;
    logic irq_any;
    logic [7:0] hi_cnt_reg;
    // scan flag only counts in the auto scan mode
    assign irq_any = |(IRQ_ENABLE & {EVENTS[3:2],
        EVENTS.scan_ready & AUTO_SCAN_MODE, EVENTS.data_ready});
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) hi_cnt_reg <= 8'h00;
        else hi_cnt_reg <= BUSY_INT_PIN ? hi_cnt_reg + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    chk_start_follow: assert property (RESULT_READ && SYS_CFG[0]
        |=> SERIAL_START) else $error("serial start missing");
    chk_start_quiet: assert property (!(RESULT_READ && SYS_CFG[0])
        |=> !SERIAL_START) else $error("serial start spurious");
    chk_cfg_hold: assert property ((CS_N && !SOFT_RESET)[*8]
        |=> $stable(SYS_CFG) && $stable(IRQ_ENABLE))
        else $error("config changed without a frame");
    chk_irq_level: assert property ((!SYS_CFG[4] && !SYS_CFG[2]
        && $stable(irq_any) && $stable(SYS_CFG))[*3]
        |-> BUSY_INT_PIN == (irq_any == SYS_CFG[3])) else $error("irq pin");
    chk_pin_busy: assert property ((SYS_CFG[2] && $stable(CONV_BUSY)
        && $stable(SYS_CFG))[*5] |-> BUSY_INT_PIN == (CONV_BUSY == SYS_CFG[3]))
        else $error("busy pin");
    chk_pulse_len: assert property ($fell(BUSY_INT_PIN) && SYS_CFG[4:2] == 3'h6
        && $past(SYS_CFG, 8) == SYS_CFG |-> hi_cnt_reg == PW)
        else $error("pulse length");
    chk_oe_select: assert property ($stable(CS_N)[*4]
        |-> SDOUT_OE == !CS_N) else $error("output enable");
    chk_soft_defaults: assert property ($rose(SOFT_RESET) |-> ##[1:6]
        (SYS_CFG == 8'h00 && IRQ_ENABLE == 4'h0 && !POWER_DOWN
        && CHANNEL_SEL == 3'h0)) else $error("soft reset defaults");
    cover property ($rose(SERIAL_START));
    cover property ($fell(BUSY_INT_PIN) && SYS_CFG[4]);
    cover property ($rose(POWER_DOWN));
endmodule // acscr_assertions

bind acscr_top acscr_assertions #(.PULSE_NS(PULSE_NS), .CLK_MHZ(CLK_MHZ))
    u_chk (.CLK(CLK), .NRST(NRST), .SOFT_RESET(SOFT_RESET), .CS_N(CS_N),
    .SDOUT_OE(SDOUT_OE), .AUTO_SCAN_MODE(AUTO_SCAN_MODE),
    .CONV_BUSY(CONV_BUSY), .RESULT_READ(RESULT_READ), .EVENTS(EVENTS),
    .CHANNEL_SEL(CHANNEL_SEL), .SYS_CFG(SYS_CFG), .POWER_DOWN(POWER_DOWN),
    .IRQ_ENABLE(IRQ_ENABLE), .SERIAL_START(SERIAL_START),
    .BUSY_INT_PIN(BUSY_INT_PIN));

// [sim/acscr_host.sv]
// host model driving the serial register port
// assumes callers at a falling CLK edge; sclk half period four CLK
`timescale 1ns/10ps
module acscr_host (
    input wire logic CLK,
    output logic CS_N,
    output logic SCLK,
    output logic SDIN,
    input wire logic SDOUT
);
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SDIN = 1'b1;
    end
    // sclk stands low between frames; idle data is the inverse
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        CS_N = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            SDIN = w[i];
            repeat (4) @(negedge CLK);
            if (i < 8) rd[i] = SDOUT;
            SCLK = 1'b1;
            repeat (4) @(negedge CLK);
            SCLK = 1'b0;
        end
        repeat (4) @(negedge CLK);
        CS_N = 1'b1;
        SDIN = ~w[0];
        repeat (12) @(negedge CLK);
    endtask
endmodule // acscr_host

// [sim/acscr_tb_top.sv]
// self-checking bench for the converter configuration register bank
// assumes the host model on the serial pins; events driven here
`timescale 1ns/10ps
`include "acscr_consts.svh"
module acscr_tb_top;
    logic CLK = 1'b0, NRST = 1'b0, SOFT_RESET = 1'b0, AUTO_SCAN_MODE = 1'b0;
    logic CONV_BUSY = 1'b0, RESULT_READ = 1'b0;
    acscr_pkg::acscr_events_t EVENTS = 4'h0;
    logic CS_N, SCLK, SDIN, SDOUT, SDOUT_OE, POWER_DOWN, SERIAL_START;
    logic BUSY_INT_PIN;
    logic [2:0] CHANNEL_SEL;
    logic [3:0] IRQ_ENABLE;
    acscr_pkg::acscr_pair_t [3:0] PAIR_CFG;
    acscr_pkg::acscr_sys_t SYS_CFG;
    logic [7:0] v;
    int fails = 0, num_checks = 0;
    always #25 CLK = ~CLK;
    acscr_top dut (.CLK(CLK), .NRST(NRST), .SOFT_RESET(SOFT_RESET),
        .CS_N(CS_N), .SCLK(SCLK), .SDIN(SDIN), .SDOUT(SDOUT),
        .SDOUT_OE(SDOUT_OE), .AUTO_SCAN_MODE(AUTO_SCAN_MODE),
        .CONV_BUSY(CONV_BUSY), .RESULT_READ(RESULT_READ), .EVENTS(EVENTS),
        .PAIR_CFG(PAIR_CFG), .CHANNEL_SEL(CHANNEL_SEL), .SYS_CFG(SYS_CFG),
        .POWER_DOWN(POWER_DOWN), .IRQ_ENABLE(IRQ_ENABLE),
        .SERIAL_START(SERIAL_START), .BUSY_INT_PIN(BUSY_INT_PIN));
    acscr_host host (.CLK(CLK), .CS_N(CS_N), .SCLK(SCLK), .SDIN(SDIN),
        .SDOUT(SDOUT));
    task automatic chk(input string n, input logic [7:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer({`ACSCR_OP_WRITE, a, 2'h0, d}, v);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        host.xfer({`ACSCR_OP_READ, a, 2'h0, 8'h00}, v);
        chk($sformatf("reg %h", a), v, e);
    endtask
    task automatic t_regs;
        logic [7:0] d;
        for (int i = 0; i < 7; i++) rd(4'(i), 8'h00);
        rd(4'hB, 8'h00);
        chk("pin idle", BUSY_INT_PIN, 8'h01);
        for (int i = 0; i < 4; i++) begin
            d = 8'hC0 | 8'(i * 21);
            wr(4'(i), d);
            chk("pair", 8'(PAIR_CFG[i]), d & 8'h3F);
            rd(4'(i), d & 8'h3F);
        end
        wr(4'h4, 8'hFD);
        rd(4'h4, 8'h05);
        for (int c = 0; c < 8; c++) begin
            wr(4'h5, {3'(c), 5'h02});
            chk("average", 8'(SYS_CFG.average_sel), 8'(c));
        end
        chk("fifo", 8'(SYS_CFG.fifo_enable), 8'h01);
        rd(4'h5, 8'hE2);
        $display("register test done");
    endtask
    task automatic t_irq;
        int n = 0;
        wr(4'h5, 8'h00);
        wr(4'h6, 8'hFF);
        chk("enables", {POWER_DOWN, 3'h0, IRQ_ENABLE}, 8'h8F);
        rd(4'h6, 8'h80);
        EVENTS = 4'hF;
        rd(4'h6, 8'h8D);
        chk("level pin", BUSY_INT_PIN, 8'h00);
        AUTO_SCAN_MODE = 1'b1;
        rd(4'h6, 8'h8F);
        EVENTS = 4'h0;
        wr(4'h6, 8'h01);
        wr(4'h5, 8'h18);
        EVENTS = 4'h1;
        repeat (20) @(negedge CLK) n += BUSY_INT_PIN;
        chk("pulse", 8'(n), 8'(`ACSCR_PULSE_NS * `ACSCR_CLK_MHZ / 1000));
        EVENTS = 4'h0;
        // config is written only while busy is low
        for (int p = 0; p < 2; p++) begin
            wr(4'h5, p ? 8'h0C : 8'h04);
            CONV_BUSY = 1'b1;
            repeat (6) @(negedge CLK);
            chk("busy pin", BUSY_INT_PIN, 8'(p));
            CONV_BUSY = 1'b0;
            repeat (6) @(negedge CLK);
            chk("busy idle", BUSY_INT_PIN, 8'(p == 0));
        end
        $display("interrupt test done");
    endtask
    task automatic t_ctl;
        for (int s = 1; s >= 0; s--) begin
            wr(4'h5, 8'(s));
            RESULT_READ = 1'b1;
            @(negedge CLK) RESULT_READ = 1'b0;
            chk("start", SERIAL_START, 8'(s));
        end
        wr(4'h6, 8'h80);
        SOFT_RESET = 1'b1;
        repeat (8) @(negedge CLK) SOFT_RESET = 1'b0;
        rd(4'h6, 8'h00);
        rd(4'h4, 8'h00);
        host.xfer({2'h3, 4'h4, 2'h0, 8'h07}, v);
        chk("bad op", 8'(CHANNEL_SEL), 8'h00);
        $display("control test done");
    endtask
    task automatic results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge CLK);
        fails++;
        results();
    end
    initial begin
        repeat (6) @(negedge CLK);
        NRST = 1'b1;
        repeat (8) @(negedge CLK);
        t_regs();
        t_irq();
        t_ctl();
        results();
    end
endmodule // acscr_tb_top
